// [csf_pkg.sv]
// Constants and state type for the CPU status flag register
//
// How it works
// - Bit 15 follows accumulator A overflow
// - Bit 14 follows accumulator B overflow
// - Bit 13 sticky accumulator A saturation
// - Bit 12 sticky accumulator B saturation
// - Bit 11 is OR of overflows
// - Bit 10 is OR of saturations
// - Write sticky bits directly, or clear via bit 10
// - Bit 9 shows do loop running
// - Bit 8 half carry, byte or word
// - Bits 7..5 low priority, msb elsewhere
// - Msb set or level 7 blocks interrupts
// - Nesting disable locks bits 7..5 against status writes
// - Bit 4 shows repeat loop running
// - Bit 3 negative result
// - Bit 2 signed overflow
// - Bit 1 zero, cleared by nonzero
// - Bit 0 carry out of msb
// - All model registers memory mapped
// - Loop start address registers read only
// - Priority msb in core control bit 3
package csf_pkg;
    // -------------------------------------------------------------
    // Register addresses (byte addresses, word access)
    // -------------------------------------------------------------
    localparam logic [15:0] ADDR_STATUS    = 16'h0042;
    localparam logic [15:0] ADDR_CORE_CTRL = 16'h0044;
    localparam logic [15:0] ADDR_LOOP_LO   = 16'h003a;
    localparam logic [15:0] ADDR_LOOP_HI   = 16'h003c;
    localparam logic [15:0] STATUS_RESET   = 16'h0000;

    // -------------------------------------------------------------
    // Status bit positions
    // -------------------------------------------------------------
    localparam int unsigned BIT_OA  = 15;
    localparam int unsigned BIT_OB  = 14;
    localparam int unsigned BIT_SA  = 13;
    localparam int unsigned BIT_SB  = 12;
    localparam int unsigned BIT_OAB = 11;
    localparam int unsigned BIT_SAB = 10;
    localparam int unsigned BIT_DA  = 9;
    localparam int unsigned BIT_DC  = 8;
    localparam int unsigned BIT_IPH = 7;
    localparam int unsigned BIT_IPL = 5;
    localparam int unsigned BIT_RA  = 4;
    localparam int unsigned BIT_N   = 3;
    localparam int unsigned BIT_OV  = 2;
    localparam int unsigned BIT_Z   = 1;
    localparam int unsigned BIT_C   = 0;
    localparam int unsigned BIT_PRIO_MSB = 3;

    // ALU flag mask positions
    localparam int unsigned MSK_C  = 0;
    localparam int unsigned MSK_Z  = 1;
    localparam int unsigned MSK_OV = 2;
    localparam int unsigned MSK_N  = 3;
    localparam int unsigned MSK_DC = 4;

    localparam logic [2:0] PRIO_LOW_BLOCK = 3'h7;
    localparam int unsigned LOOP_HI_W = 7;

    typedef struct packed {
        logic        accAOvf;
        logic        accBOvf;
        logic        accASat;
        logic        accBSat;
        logic        doLoop;
        logic        halfCarry;
        logic [2:0]  prioLow;
        logic        rptLoop;
        logic        neg;
        logic        wrap;
        logic        zero;
        logic        carry;
        logic        prioMsb;
        logic [LOOP_HI_W-1:0] loopHi;
        logic [15:0] loopLo;
        logic [15:0] view;
        logic [15:0] rdData;
        logic        userBlk;
    } csf_state_s;
endpackage

// [csf_acc_next.sv]
// Next-state logic of one accumulator's overflow and sticky saturation flags
`timescale 1ns/1ps
module csf_acc_next
    import csf_pkg::*;
(
    input  wire logic ovfQ,
    input  wire logic satQ,
    input  wire logic ovfUpd,
    input  wire logic ovfIn,
    input  wire logic satEvt,
    input  wire logic swWr,
    input  wire logic swOvf,
    input  wire logic swOvfAll,
    input  wire logic swSat,
    input  wire logic swSatAll,
    output logic      ovfD,
    output logic      satD
);
    always_comb begin
        ovfD = ovfQ;
        satD = satQ;
        if (ovfUpd) begin
            ovfD = ovfIn;
        end
        if (swWr) begin
            ovfD = swOvf & swOvfAll;
            satD = swSat & swSatAll;
        end
        if (satEvt) begin
            satD = 1'b1;
        end
    end
endmodule

// [csf_status_reg.sv]
// CPU status flag register with core control priority msb and loop start registers
`timescale 1ns/1ps
module csf_status_reg
    import csf_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        dsWrEn,
    input  wire logic        dsRdEn,
    input  wire logic [15:0] dsAddr,
    input  wire logic [15:0] dsWrData,
    input  wire logic        aluValid,
    input  wire logic        aluByte,
    input  wire logic [15:0] aluA,
    input  wire logic [15:0] aluB,
    input  wire logic        aluCin,
    input  wire logic [4:0]  aluMask,
    input  wire logic        aluZeroKeep,
    input  wire logic        accOvfAUpd,
    input  wire logic        accOvfAIn,
    input  wire logic        accOvfBUpd,
    input  wire logic        accOvfBIn,
    input  wire logic        accSatAEvt,
    input  wire logic        accSatBEvt,
    input  wire logic        doLoopRun,
    input  wire logic        repeatRun,
    input  wire logic        prioLoad,
    input  wire logic [3:0]  prioValue,
    input  wire logic        nestingDisable,
    input  wire logic        loopStartLoad,
    input  wire logic [22:0] loopStartAddr,
    output logic [15:0]      dsRdData,
    output logic [15:0]      statusFlags,
    output logic [3:0]       cpuPriority,
    output logic             userIntBlocked
);
    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    csf_state_s s_q;
    csf_state_s s_d;

    logic statusWr;
    logic coreWr;
    logic accAOvfD;
    logic accASatD;
    logic accBOvfD;
    logic accBSatD;
    logic [4:0]  nibSum;
    logic [8:0]  byteSum;
    logic [16:0] wordSum;
    logic resCarry;
    logic resHalf;
    logic resNeg;
    logic resWrap;
    logic resZero;

    // -------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------
    // memory mapped access
    always_comb begin
        statusWr = 1'b0;
        coreWr   = 1'b0;
        if (dsWrEn && dsAddr == ADDR_STATUS) begin
            statusWr = 1'b1;
        end else if (dsWrEn && dsAddr == ADDR_CORE_CTRL) begin
            coreWr = 1'b1;
        end
    end

    // -------------------------------------------------------------
    // ALU result flags
    // -------------------------------------------------------------
    // Subtraction arrives as inverted operand plus carry in,
    // so carry bits read as not-borrow.
    always_comb begin
        nibSum  = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]} + {4'h0, aluCin};
        byteSum = {1'b0, aluA[7:0]} + {1'b0, aluB[7:0]} + {8'h00, aluCin};
        wordSum = {1'b0, aluA} + {1'b0, aluB} + {16'h0000, aluCin};
        if (aluByte) begin
            resHalf  = nibSum[4];
            resCarry = byteSum[8];
            resNeg   = byteSum[7];
            resWrap  = (aluA[7] == aluB[7]) && (byteSum[7] != aluA[7]);
            resZero  = (byteSum[7:0] == 8'h00);
        end else begin
            resHalf  = byteSum[8];
            resCarry = wordSum[16];
            resNeg   = wordSum[15];
            resWrap  = (aluA[15] == aluB[15]) && (wordSum[15] != aluA[15]);
            resZero  = (wordSum[15:0] == 16'h0000);
        end
    end

    // -------------------------------------------------------------
    // Accumulator flags
    // -------------------------------------------------------------
    csf_acc_next accANext (
        .ovfQ     (s_q.accAOvf),
        .satQ     (s_q.accASat),
        .ovfUpd   (accOvfAUpd),
        .ovfIn    (accOvfAIn),
        .satEvt   (accSatAEvt),
        .swWr     (statusWr),
        .swOvf    (dsWrData[BIT_OA]),
        .swOvfAll (dsWrData[BIT_OAB]),
        .swSat    (dsWrData[BIT_SA]),
        .swSatAll (dsWrData[BIT_SAB]),
        .ovfD     (accAOvfD),
        .satD     (accASatD)
    );

    csf_acc_next accBNext (
        .ovfQ     (s_q.accBOvf),
        .satQ     (s_q.accBSat),
        .ovfUpd   (accOvfBUpd),
        .ovfIn    (accOvfBIn),
        .satEvt   (accSatBEvt),
        .swWr     (statusWr),
        .swOvf    (dsWrData[BIT_OB]),
        .swOvfAll (dsWrData[BIT_OAB]),
        .swSat    (dsWrData[BIT_SB]),
        .swSatAll (dsWrData[BIT_SAB]),
        .ovfD     (accBOvfD),
        .satD     (accBSatD)
    );

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.accAOvf = accAOvfD;
        s_d.accBOvf = accBOvfD;
        s_d.accASat = accASatD;
        s_d.accBSat = accBSatD;
        s_d.doLoop  = doLoopRun;
        s_d.rptLoop = repeatRun;

        if (aluValid) begin
            if (aluMask[MSK_C]) begin
                s_d.carry = resCarry;
            end
            if (aluMask[MSK_DC]) begin
                s_d.halfCarry = resHalf;
            end
            if (aluMask[MSK_N]) begin
                s_d.neg = resNeg;
            end
            if (aluMask[MSK_OV]) begin
                s_d.wrap = resWrap;
            end
            if (aluMask[MSK_Z]) begin
                if (!resZero) begin
                    s_d.zero = 1'b0;
                end else if (!aluZeroKeep) begin
                    s_d.zero = 1'b1;
                end
            end
        end

        if (prioLoad) begin
            s_d.prioLow = prioValue[2:0];
            s_d.prioMsb = prioValue[BIT_PRIO_MSB];
        end

        if (loopStartLoad) begin
            s_d.loopHi = loopStartAddr[22:16];
            s_d.loopLo = loopStartAddr[15:0];
        end

        if (statusWr) begin
            s_d.halfCarry = dsWrData[BIT_DC];
            s_d.neg       = dsWrData[BIT_N];
            s_d.wrap      = dsWrData[BIT_OV];
            s_d.zero      = dsWrData[BIT_Z];
            s_d.carry     = dsWrData[BIT_C];
            if (!nestingDisable) begin
                s_d.prioLow = dsWrData[BIT_IPH:BIT_IPL];
            end
        end

        if (coreWr && !dsWrData[BIT_PRIO_MSB]) begin
            s_d.prioMsb = 1'b0;
        end

        s_d.view = {s_d.accAOvf, s_d.accBOvf, s_d.accASat, s_d.accBSat,
                    s_d.accAOvf | s_d.accBOvf, s_d.accASat | s_d.accBSat,
                    s_d.doLoop, s_d.halfCarry, s_d.prioLow, s_d.rptLoop,
                    s_d.neg, s_d.wrap, s_d.zero, s_d.carry};

        s_d.userBlk = s_d.prioMsb || (s_d.prioLow == PRIO_LOW_BLOCK);

        // Read returns the value before any same-cycle write
        s_d.rdData = 16'h0000;
        if (dsRdEn) begin
            if (dsAddr == ADDR_STATUS) begin
                s_d.rdData = s_q.view;
            end else if (dsAddr == ADDR_CORE_CTRL) begin
                s_d.rdData[BIT_PRIO_MSB] = s_q.prioMsb;
            end else if (dsAddr == ADDR_LOOP_LO) begin
                s_d.rdData = s_q.loopLo;
            end else if (dsAddr == ADDR_LOOP_HI) begin
                s_d.rdData[LOOP_HI_W-1:0] = s_q.loopHi;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dsRdData       = s_q.rdData;
    assign statusFlags    = s_q.view;
    assign cpuPriority    = {s_q.prioMsb, s_q.prioLow};
    assign userIntBlocked = s_q.userBlk;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    // Word sum formed apart from the flag logic, so the word checks below are not circular
    logic [16:0] chkSum;
    assign chkSum = {aluA[15], aluA} + {aluB[15], aluB} + {16'h0000, aluCin};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_ovf_a_follow: assert property (
        accOvfAUpd && !statusWr |=> statusFlags[BIT_OA] == $past(accOvfAIn))
        else $error("accumulator A overflow not followed");

    a_ovf_b_follow: assert property (
        accOvfBUpd && !statusWr |=> statusFlags[BIT_OB] == $past(accOvfBIn))
        else $error("accumulator B overflow not followed");

    a_sat_a_sticky: assert property (
        accSatAEvt ##1 !statusWr [*3] |-> statusFlags[BIT_SA])
        else $error("sticky A saturation lost");

    a_sat_b_set: assert property (
        accSatBEvt |=> statusFlags[BIT_SB])
        else $error("B saturation event not recorded");

    a_or_ovf_view: assert property (
        statusFlags[BIT_OAB] == (statusFlags[BIT_OA] | statusFlags[BIT_OB]))
        else $error("combined overflow wrong");

    a_or_sat_view: assert property (
        statusFlags[BIT_SAB] == (statusFlags[BIT_SA] | statusFlags[BIT_SB]))
        else $error("combined saturation wrong");

    a_sab_clear: assert property (
        statusWr && !dsWrData[BIT_SAB] && !accSatAEvt && !accSatBEvt
        |=> !statusFlags[BIT_SA] && !statusFlags[BIT_SB])
        else $error("clearing combined saturation did not clear both");

    a_loop_flags: assert property (
        ##1 statusFlags[BIT_DA] == $past(doLoopRun)
            && statusFlags[BIT_RA] == $past(repeatRun))
        else $error("loop indicator does not follow loop hardware");

    a_half_byte: assert property (
        aluValid && aluByte && aluMask[MSK_DC] && !statusWr
        |=> statusFlags[BIT_DC] == $past(nibSum[4]))
        else $error("byte half carry wrong");

    a_user_block: assert property (
        userIntBlocked == (cpuPriority[BIT_PRIO_MSB]
                           || cpuPriority[2:0] == PRIO_LOW_BLOCK))
        else $error("user interrupt block wrong");

    a_prio_locked: assert property (
        statusWr && nestingDisable && !prioLoad
        |=> $stable(cpuPriority[2:0]))
        else $error("priority written while nesting disabled");

    a_zero_clear: assert property (
        aluValid && aluMask[MSK_Z] && !resZero && !statusWr
        |=> !statusFlags[BIT_Z])
        else $error("nonzero result did not clear zero");

    a_loop_ro: assert property (
        !loopStartLoad |=> $stable(s_q.loopLo) && $stable(s_q.loopHi))
        else $error("loop start address changed by software");

    a_msb_clear: assert property (
        coreWr && !dsWrData[BIT_PRIO_MSB] && !prioLoad
        |=> !cpuPriority[BIT_PRIO_MSB])
        else $error("priority msb not cleared");

    a_sw_wins: assert property (
        statusWr && aluValid |=> statusFlags[BIT_C] == $past(dsWrData[BIT_C]))
        else $error("hardware update beat software write");

    a_word_carry: assert property (
        aluValid && !aluByte && aluMask[MSK_C] && !statusWr
        |=> statusFlags[BIT_C] == $past((aluA[15] & aluB[15])
                                        | ((aluA[15] ^ aluB[15]) & ~chkSum[15])))
        else $error("word carry wrong");

    a_word_half: assert property (
        aluValid && !aluByte && aluMask[MSK_DC] && !statusWr
        |=> statusFlags[BIT_DC] == $past((aluA[7] & aluB[7])
                                         | ((aluA[7] ^ aluB[7]) & ~chkSum[7])))
        else $error("word half carry wrong");

    a_word_neg: assert property (
        aluValid && !aluByte && aluMask[MSK_N] && !statusWr
        |=> statusFlags[BIT_N] == $past(chkSum[15]))
        else $error("word negative flag wrong");

    a_word_wrap: assert property (
        aluValid && !aluByte && aluMask[MSK_OV] && !statusWr
        |=> statusFlags[BIT_OV] == $past(chkSum[16] ^ chkSum[15]))
        else $error("word signed overflow wrong");

    a_prio_load: assert property (
        prioLoad && !statusWr && !coreWr
        |=> cpuPriority == $past(prioValue))
        else $error("priority load not applied");

    c_byte_op:    cover property (aluValid && aluByte && resHalf);
    c_sab_clear:  cover property (statusWr && !dsWrData[BIT_SAB] && s_q.accASat);
    c_sat_race:   cover property (statusWr && accSatAEvt);
    c_block_rise: cover property ($rose(userIntBlocked));
    c_prio_lock:  cover property (statusWr && nestingDisable);
endmodule

// [tb_top.sv]
// Self-checking testbench for the CPU status flag register
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top
    import csf_pkg::*;
;
    // --------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------
    typedef struct packed {
        logic        byteOp;
        logic [15:0] a;
        logic [15:0] b;
        logic        cin;
        logic [4:0]  mask;
        logic [4:0]  exp;
    } csf_row_s;

    logic mclk, srst, dsWrEn, dsRdEn, aluValid, aluByte, aluCin, aluZeroKeep;
    logic accOvfAUpd, accOvfAIn, accOvfBUpd, accOvfBIn, accSatAEvt, accSatBEvt;
    logic doLoopRun, repeatRun, prioLoad, nestingDisable, loopStartLoad;
    logic [15:0] dsAddr, dsWrData, aluA, aluB, dsRdData, statusFlags;
    logic [4:0]  aluMask;
    logic [3:0]  prioValue, cpuPriority;
    logic [22:0] loopStartAddr;
    logic        userIntBlocked;
    int          errors;
    int          checked;

    // Expected flags as {half carry, negative, signed wrap, zero, carry}
    csf_row_s rows [9] = '{
        '{1'b1, 16'h000f, 16'h0001, 1'b0, 5'h1f, 5'b10000},
        '{1'b1, 16'h007f, 16'h0001, 1'b0, 5'h1f, 5'b11100},
        '{1'b1, 16'h00ff, 16'h0001, 1'b0, 5'h1f, 5'b10011},
        '{1'b0, 16'h00ff, 16'h0001, 1'b0, 5'h1f, 5'b10000},
        '{1'b0, 16'h7fff, 16'h0001, 1'b0, 5'h1f, 5'b11100},
        '{1'b0, 16'h8000, 16'h8000, 1'b0, 5'h1f, 5'b00111},
        '{1'b0, 16'h0005, 16'hfffa, 1'b1, 5'h1f, 5'b10011},
        '{1'b0, 16'h1234, 16'h0000, 1'b0, 5'h01, 5'b10010},
        '{1'b1, 16'h0100, 16'h0000, 1'b0, 5'h1f, 5'b00010}
    };

    csf_status_reg csf_status_reg_i (
        .mclk(mclk), .srst(srst), .dsWrEn(dsWrEn), .dsRdEn(dsRdEn), .dsAddr(dsAddr),
        .dsWrData(dsWrData), .aluValid(aluValid), .aluByte(aluByte), .aluA(aluA),
        .aluB(aluB), .aluCin(aluCin), .aluMask(aluMask), .aluZeroKeep(aluZeroKeep),
        .accOvfAUpd(accOvfAUpd), .accOvfAIn(accOvfAIn), .accOvfBUpd(accOvfBUpd),
        .accOvfBIn(accOvfBIn), .accSatAEvt(accSatAEvt), .accSatBEvt(accSatBEvt),
        .doLoopRun(doLoopRun), .repeatRun(repeatRun), .prioLoad(prioLoad),
        .prioValue(prioValue), .nestingDisable(nestingDisable),
        .loopStartLoad(loopStartLoad), .loopStartAddr(loopStartAddr),
        .dsRdData(dsRdData), .statusFlags(statusFlags), .cpuPriority(cpuPriority),
        .userIntBlocked(userIntBlocked)
    );

    always #5 mclk = ~mclk;

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    // Drops every pulse at the sampling edge, then lets its updates land
    task pulse_end;
        @(posedge mclk);
        dsWrEn <= 1'b0; dsRdEn <= 1'b0; aluValid <= 1'b0; prioLoad <= 1'b0;
        accOvfAUpd <= 1'b0; accOvfBUpd <= 1'b0; accSatAEvt <= 1'b0;
        accSatBEvt <= 1'b0; loopStartLoad <= 1'b0;
        #1;
    endtask

    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        dsWrEn <= 1'b1; dsAddr <= a; dsWrData <= d;
    endtask

    task rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge mclk);
        dsRdEn <= 1'b1; dsAddr <= a;
        pulse_end;
        `CHK("read data", e, dsRdData)
    endtask

    task alu(input csf_row_s r);
        aluValid <= 1'b1; aluByte <= r.byteOp; aluA <= r.a; aluB <= r.b;
        aluCin <= r.cin; aluMask <= r.mask;
    endtask

    task wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task print_verdict;
        if (errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        #20us;
        errors++;
        print_verdict;
    end

    initial begin
        mclk = 0; srst = 1; errors = 0; checked = 0;
        {dsWrEn, dsRdEn, aluValid, aluByte, aluCin, aluZeroKeep} = '0;
        {accOvfAUpd, accOvfAIn, accOvfBUpd, accOvfBIn, accSatAEvt, accSatBEvt} = '0;
        {doLoopRun, repeatRun, prioLoad, nestingDisable, loopStartLoad} = '0;
        dsAddr = '0; dsWrData = '0; aluA = '0; aluB = '0; aluMask = '0;
        prioValue = '0; loopStartAddr = '0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        #1;
        `CHK("reset status", STATUS_RESET, statusFlags)
        `CHK("reset priority", 4'h0, cpuPriority)
        `CHK("reset blocked", 1'b0, userIntBlocked)
        foreach (rows[i]) begin
            @(posedge mclk);
            alu(rows[i]);
            pulse_end;
            `CHK("alu flags", rows[i].exp, {statusFlags[8], statusFlags[3:0]})
        end
        // Nonzero clears zero, then a kept zero result leaves it clear
        @(posedge mclk); alu('{1'b0, 16'h0001, 16'h0000, 1'b0, 5'h1f, 5'h0}); pulse_end;
        `CHK("zero clear", 1'b0, statusFlags[1])
        @(posedge mclk); aluZeroKeep <= 1'b1;
        alu('{1'b0, 16'h0000, 16'h0000, 1'b0, 5'h1f, 5'h0}); pulse_end;
        `CHK("zero keep", 1'b0, statusFlags[1])
        aluZeroKeep <= 1'b0;
        // Software writes: combined bits follow, loop bits ignored
        wr(ADDR_STATUS, 16'hffff); pulse_end;
        `CHK("write all", 16'hfdef, statusFlags)
        wait_cyc(1);
        `CHK("level 7 blocks", 1'b1, userIntBlocked)
        `CHK("priority low", 4'h7, cpuPriority)
        rd(ADDR_STATUS, 16'hfdef);
        wait_cyc(1);
        `CHK("read released", 16'h0000, dsRdData)
        wr(ADDR_STATUS, 16'hf7ff); pulse_end;
        `CHK("clear overflow", 16'h35ef, statusFlags)
        wr(ADDR_STATUS, 16'h3bff); pulse_end;
        `CHK("clear sticky", 16'h01ef, statusFlags)
        wr(ADDR_STATUS, 16'h0000); pulse_end;
        // Accumulator overflow follows, saturation sticks
        @(posedge mclk); accSatAEvt <= 1'b1; pulse_end; wait_cyc(2);
        `CHK("sticky a", 2'b11, {statusFlags[13], statusFlags[10]})
        @(posedge mclk); accSatBEvt <= 1'b1; pulse_end;
        `CHK("sticky b", 1'b1, statusFlags[12])
        @(posedge mclk); accOvfAUpd <= 1'b1; accOvfAIn <= 1'b1; pulse_end;
        `CHK("ovf a set", 2'b11, {statusFlags[15], statusFlags[11]})
        @(posedge mclk); accOvfAUpd <= 1'b1; accOvfAIn <= 1'b0; pulse_end;
        `CHK("ovf a clear", 2'b00, {statusFlags[15], statusFlags[11]})
        @(posedge mclk); accOvfBUpd <= 1'b1; accOvfBIn <= 1'b1; pulse_end;
        `CHK("ovf b set", 2'b11, {statusFlags[14], statusFlags[11]})
        @(posedge mclk); accOvfBUpd <= 1'b1; accOvfBIn <= 1'b0; pulse_end;
        `CHK("ovf b clear", 1'b0, statusFlags[14])
        // Same-cycle write against alu and saturation event
        wr(ADDR_STATUS, 16'h0000); accSatAEvt <= 1'b1; alu(rows[5]); pulse_end;
        `CHK("write collision", 16'h2400, statusFlags)
        // Priority msb and user interrupt blocking
        @(posedge mclk); prioLoad <= 1'b1; prioValue <= 4'h8; pulse_end;
        `CHK("msb priority", 5'h18, {userIntBlocked, cpuPriority})
        @(posedge mclk); prioLoad <= 1'b1; prioValue <= 4'h6; pulse_end;
        `CHK("level 6", 5'h06, {userIntBlocked, cpuPriority})
        `CHK("level 6 bits", 3'h6, statusFlags[7:5])
        @(posedge mclk); prioLoad <= 1'b1; prioValue <= 4'hb; pulse_end;
        rd(ADDR_CORE_CTRL, 16'h0008);
        wr(ADDR_CORE_CTRL, 16'h0000); pulse_end; wait_cyc(1);
        `CHK("msb cleared", 5'h03, {userIntBlocked, cpuPriority})
        // Nesting disable locks the low priority bits
        @(posedge mclk); nestingDisable <= 1'b1;
        wr(ADDR_STATUS, 16'h00e0); pulse_end;
        `CHK("prio locked", 3'h3, statusFlags[7:5])
        @(posedge mclk); nestingDisable <= 1'b0;
        // Loop activity bits
        @(posedge mclk); doLoopRun <= 1'b1; repeatRun <= 1'b1; wait_cyc(2);
        wr(ADDR_STATUS, 16'h0000); pulse_end;
        `CHK("loops active", 2'b11, {statusFlags[9], statusFlags[4]})
        @(posedge mclk); doLoopRun <= 1'b0; wait_cyc(2);
        `CHK("do loop idle", 2'b01, {statusFlags[9], statusFlags[4]})
        @(posedge mclk); repeatRun <= 1'b0; wait_cyc(2);
        `CHK("repeat idle", 1'b0, statusFlags[4])
        // Loop start registers load by hardware only
        @(posedge mclk); loopStartLoad <= 1'b1; loopStartAddr <= 23'h5abcde; pulse_end;
        wr(ADDR_LOOP_LO, 16'h1111); pulse_end;
        wr(ADDR_LOOP_HI, 16'h0011); pulse_end;
        rd(ADDR_LOOP_LO, 16'hbcde);
        rd(ADDR_LOOP_HI, 16'h005a);
        rd(16'h0100, 16'h0000);
        // Mid-run reset clears every output
        @(posedge mclk); prioLoad <= 1'b1; prioValue <= 4'hf; accSatBEvt <= 1'b1;
        pulse_end;
        @(posedge mclk); srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        #1;
        `CHK("mid reset status", STATUS_RESET, statusFlags)
        `CHK("mid reset priority", 5'h00, {userIntBlocked, cpuPriority})
        `CHK("mid reset read", 16'h0000, dsRdData)
        wait_cyc(1);
        `CHK("after reset status", STATUS_RESET, statusFlags)
        print_verdict;
    end
endmodule
